/* shts_map.svh */
// Purpose: Offsets, field positions, reset values and timings
// Assumes: 40 MHz system clock, 1 ms phase resolution
// Notes:   Byte addresses, one 32-bit word per register
`ifndef SHTS_MAP_SVH
`define SHTS_MAP_SVH
`define SHTS_CLK_HZ        40000000
`define SHTS_TICK_MS       1
`define SHTS_TICK_CYC      (`SHTS_CLK_HZ / 1000 * `SHTS_TICK_MS)
`define SHTS_ID_MS         2000
`define SHTS_FLASH_MS      250
`define SHTS_DUR_MIN_MS    20'h00001
`define SHTS_DUR_MAX_MS    20'hF423F
`define SHTS_RPT_MIN       7'h01
`define SHTS_RPT_MAX       7'h63
`define SHTS_RST_OPEN_MS   20'h003E8
`define SHTS_RST_CLOSED_MS 20'h003E8
`define SHTS_RST_RPT       7'h01
`define SHTS_OFS_CTRL      8'h00
`define SHTS_OFS_STEP      8'h04
`define SHTS_OFS_OPEN      8'h08
`define SHTS_OFS_CLOSED    8'h0C
`define SHTS_OFS_REPEAT    8'h10
`define SHTS_OFS_STATUS    8'h14
`define SHTS_CTRL_TRIG     0
`define SHTS_CTRL_SELC     1
`define SHTS_CTRL_MODE_LO  4
`define SHTS_STEP_UP       0
`define SHTS_STEP_DN       1
`define SHTS_ST_EN         0
`define SHTS_ST_DRV        1
`define SHTS_ST_DESYNC     2
`define SHTS_ST_WARN       3
`define SHTS_ST_ID         4
`define SHTS_ST_RPT_LO     8
`endif

/* shts_pkg.sv */
// Purpose: Types shared by the shutter timing sequencer
// Assumes: Constants come from shts_map.svh
// Notes:   Mode codes follow the front-panel stepping order
package shts_pkg;
   typedef enum logic [2:0] {
      MODE_SINGLE = 3'h0,
      MODE_CONT   = 3'h1,
      MODE_MANUAL = 3'h2,
      MODE_GATE   = 3'h3,
      MODE_REPEAT = 3'h4
   } shts_mode_t;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_ARMED  = 6'h02,
      ST_OPEN   = 6'h04,
      ST_CLOSED = 6'h08,
      ST_MANUAL = 6'h10,
      ST_GATE   = 6'h20
   } shts_state_t;

   typedef struct packed {
      shts_mode_t  mode;
      logic        trig_pin_sel;
      logic        sel_closed;
      logic [19:0] open_ms;
      logic [19:0] closed_ms;
      logic [6:0]  repeat_cnt;
   } shts_cfg_t;

   typedef struct packed {
      logic enable_key;
      logic trig;
      logic ilk_closed;
      logic present;
      logic sensed_open;
   } shts_pins_t;
endpackage

/* shts_seq.sv */
// Purpose: Shutter open/closed timing sequencer with interlock and alarm
// Assumes: Plain register port, pins asynchronous to clk_sys
// Notes:   Saved settings come from an external nonvolatile store
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "shts_map.svh"

module shts_seq
   import shts_pkg::*;
#(
   parameter int unsigned TICK_CYC = `SHTS_TICK_CYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire shts_pins_t  pins,
   input  wire logic        nv_valid,
   input  wire shts_cfg_t   nv_cfg,
   output shts_cfg_t        nv_cfg_save,
   output logic             nv_save,
   output logic             coil_drive,
   output logic             ttl_out,
   output logic             enabled_led,
   output logic             interlock_warn,
   output logic             desync_alarm,
   output logic             id_screen
);

   function automatic shts_mode_t mode_step(shts_mode_t m, logic up);
      logic [2:0] v;
      v = m;
      if (up)
         v = (v == 3'h4) ? 3'h0 : 3'(v + 3'h1);
      else
         v = (v == 3'h0) ? 3'h4 : 3'(v - 3'h1);
      return shts_mode_t'(v);
   endfunction

   function automatic logic [19:0] dur_clamp(logic [31:0] d);
      if (d < 32'(`SHTS_DUR_MIN_MS))
         return `SHTS_DUR_MIN_MS;
      if (d > 32'(`SHTS_DUR_MAX_MS))
         return `SHTS_DUR_MAX_MS;
      return d[19:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edges
   shts_pins_t  pin_m_r;
   shts_pins_t  pin_s_r;
   logic        key_d_r;
   logic        trig_d_r;
   logic        key_press;
   logic        trig_edge;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pin_m_r  <= '0;
         pin_s_r  <= '0;
         key_d_r  <= 1'b0;
         trig_d_r <= 1'b0;
      end
      else
      begin
         pin_m_r  <= pins;
         pin_s_r  <= pin_m_r;
         key_d_r  <= pin_s_r.enable_key;
         trig_d_r <= pin_s_r.trig;
      end
   end

   assign key_press = pin_s_r.enable_key & ~key_d_r;
   assign trig_edge = pin_s_r.trig ^ trig_d_r;

   ////////////////////////////////////////////////////////////////////////
   // 1 ms tick, identification time, warning flash
   logic [15:0] tick_cnt_r;
   logic        tick;
   logic [11:0] id_cnt_r;
   logic        id_busy_r;
   logic [8:0]  fl_cnt_r;
   logic        blink_r;

   assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         tick_cnt_r <= 16'h0000;
      else
         tick_cnt_r <= tick ? 16'h0000 : 16'(tick_cnt_r + 16'h0001);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         id_cnt_r  <= 12'h000;
         id_busy_r <= 1'b1;
      end
      else if (id_busy_r && tick)
      begin
         id_cnt_r <= 12'(id_cnt_r + 12'h001);
         if (id_cnt_r == 12'(`SHTS_ID_MS - 1))
            id_busy_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         fl_cnt_r <= 9'h000;
         blink_r  <= 1'b0;
      end
      else if (tick)
      begin
         fl_cnt_r <= (fl_cnt_r == 9'(`SHTS_FLASH_MS - 1)) ? 9'h000
                     : 9'(fl_cnt_r + 9'h001);
         if (fl_cnt_r == 9'(`SHTS_FLASH_MS - 1))
            blink_r <= ~blink_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   shts_cfg_t   cfg_r;
   logic        nv_done_r;
   logic        wr_ctrl;

   assign wr_ctrl = reg_wr && (reg_addr == `SHTS_OFS_CTRL);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         cfg_r.mode       <= MODE_MANUAL;
         cfg_r.trig_pin_sel <= 1'b0;
         cfg_r.sel_closed <= 1'b0;
         cfg_r.open_ms    <= `SHTS_RST_OPEN_MS;
         cfg_r.closed_ms  <= `SHTS_RST_CLOSED_MS;
         cfg_r.repeat_cnt <= `SHTS_RST_RPT;
         nv_done_r        <= 1'b0;
      end
      else if (!nv_done_r)
      begin
         nv_done_r <= 1'b1;
         if (nv_valid)
            cfg_r <= nv_cfg;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `SHTS_OFS_CTRL:
            begin
               cfg_r.trig_pin_sel <= reg_wdata[`SHTS_CTRL_TRIG];
               cfg_r.sel_closed <= reg_wdata[`SHTS_CTRL_SELC];
            end
            `SHTS_OFS_STEP:
            begin
               if (reg_wdata[`SHTS_STEP_UP])
                  cfg_r.mode <= mode_step(cfg_r.mode, 1'b1);
               else if (reg_wdata[`SHTS_STEP_DN])
                  cfg_r.mode <= mode_step(cfg_r.mode, 1'b0);
            end
            `SHTS_OFS_OPEN:   cfg_r.open_ms   <= dur_clamp(reg_wdata);
            `SHTS_OFS_CLOSED: cfg_r.closed_ms <= dur_clamp(reg_wdata);
            `SHTS_OFS_REPEAT:
               cfg_r.repeat_cnt <=
                  (reg_wdata < 32'(`SHTS_RPT_MIN)) ? `SHTS_RPT_MIN
                  : (reg_wdata > 32'(`SHTS_RPT_MAX)) ? `SHTS_RPT_MAX
                  : reg_wdata[6:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   shts_state_t st_r;
   logic        drive_r;
   logic [19:0] ph_cnt_r;
   logic [6:0]  rpt_left_r;
   logic        warn_r;
   logic        ilk_drop;
   logic        expire;
   logic        cyc_end;
   shts_state_t start_st;
   logic [19:0] start_cnt;

   assign ilk_drop  = !pin_s_r.ilk_closed && pin_s_r.present
                      && (st_r != ST_IDLE);
   assign expire    = tick && (ph_cnt_r == 20'h00001);
   assign cyc_end   = (st_r == ST_CLOSED) ^ cfg_r.sel_closed;
   assign start_st  = cfg_r.sel_closed ? ST_CLOSED : ST_OPEN;
   assign start_cnt = cfg_r.sel_closed ? cfg_r.closed_ms
                      : cfg_r.open_ms;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         st_r       <= ST_IDLE;
         drive_r    <= 1'b0;
         ph_cnt_r   <= 20'h00000;
         rpt_left_r <= 7'h00;
         warn_r     <= 1'b0;
      end
      else if (id_busy_r || !nv_done_r)
      begin
         st_r <= ST_IDLE;
      end
      else if (ilk_drop)
      begin
         st_r    <= ST_IDLE;
         drive_r <= 1'b0;
         warn_r  <= 1'b1;
      end
      else if (key_press)
      begin
         if (st_r != ST_IDLE)
         begin
            st_r    <= ST_IDLE;
            drive_r <= 1'b0;
         end
         else if (pin_s_r.ilk_closed)
         begin
            warn_r     <= 1'b0;
            rpt_left_r <= cfg_r.repeat_cnt;
            if (cfg_r.mode == MODE_MANUAL)
            begin
               st_r    <= ST_MANUAL;
               drive_r <= 1'b1;
            end
            else if (cfg_r.mode == MODE_GATE)
               st_r <= ST_GATE;
            else if (cfg_r.trig_pin_sel)
               st_r <= ST_ARMED;
            else
            begin
               st_r     <= start_st;
               ph_cnt_r <= start_cnt;
               drive_r  <= !cfg_r.sel_closed;
            end
         end
      end
      else
      begin
         unique case (st_r)
            ST_ARMED:
               if (trig_edge)
               begin
                  st_r     <= start_st;
                  ph_cnt_r <= start_cnt;
                  drive_r  <= !cfg_r.sel_closed;
                  rpt_left_r <= cfg_r.repeat_cnt;
               end
            ST_OPEN, ST_CLOSED:
               if (expire && cyc_end)
               begin
                  if (cfg_r.mode == MODE_CONT
                      || (cfg_r.mode == MODE_REPEAT
                          && rpt_left_r != 7'h01))
                  begin
                     st_r       <= start_st;
                     ph_cnt_r   <= start_cnt;
                     drive_r    <= !cfg_r.sel_closed;
                     rpt_left_r <= 7'(rpt_left_r - 7'h01);
                  end
                  else
                  begin
                     st_r <= (cfg_r.mode == MODE_SINGLE && cfg_r.trig_pin_sel)
                             ? ST_ARMED : ST_IDLE;
                     drive_r    <= 1'b0;
                     rpt_left_r <= 7'h00;
                  end
               end
               else if (expire)
               begin
                  st_r     <= (st_r == ST_OPEN) ? ST_CLOSED : ST_OPEN;
                  ph_cnt_r <= (st_r == ST_OPEN) ? cfg_r.closed_ms
                              : cfg_r.open_ms;
                  drive_r  <= (st_r != ST_OPEN);
               end
               else if (tick)
                  ph_cnt_r <= 20'(ph_cnt_r - 20'h00001);
            ST_GATE:
               drive_r <= pin_s_r.trig;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alarm, outputs, snapshot of settings
   logic        drv_d_r;
   logic        desync_p;
   logic        stat_desync_r;
   logic        desync_clr;
   logic        en_accept;

   assign desync_p = pin_s_r.present && (drive_r != drv_d_r)
                     && (pin_s_r.sensed_open != drv_d_r);
   assign desync_clr = reg_wr && (reg_addr == `SHTS_OFS_STATUS)
                       && reg_wdata[`SHTS_ST_DESYNC];
   // Only an accepted enabling press snapshots the settings
   assign en_accept  = key_press && (st_r == ST_IDLE) && pin_s_r.ilk_closed
                       && nv_done_r && !id_busy_r;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         drv_d_r        <= 1'b0;
         desync_alarm   <= 1'b0;
         stat_desync_r  <= 1'b0;
         ttl_out        <= 1'b0;
         interlock_warn <= 1'b0;
         nv_save        <= 1'b0;
         nv_cfg_save    <= '0;
      end
      else
      begin
         drv_d_r        <= drive_r;
         desync_alarm   <= desync_p;
         stat_desync_r  <= desync_p | (stat_desync_r & ~desync_clr);
         ttl_out        <= pin_s_r.present ? pin_s_r.sensed_open
                           : drive_r;
         interlock_warn <= warn_r & blink_r;
         nv_save        <= en_accept;
         if (en_accept)
            nv_cfg_save <= cfg_r;
      end
   end

   assign coil_drive  = drive_r;
   assign enabled_led = (st_r != ST_IDLE);
   assign id_screen   = id_busy_r;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `SHTS_OFS_CTRL:   reg_rdata <= {25'h0, cfg_r.mode, 2'h0,
                                 cfg_r.sel_closed, cfg_r.trig_pin_sel};
            `SHTS_OFS_OPEN:   reg_rdata <= {12'h000, cfg_r.open_ms};
            `SHTS_OFS_CLOSED: reg_rdata <= {12'h000, cfg_r.closed_ms};
            `SHTS_OFS_REPEAT: reg_rdata <= {25'h0, cfg_r.repeat_cnt};
            `SHTS_OFS_STATUS: reg_rdata <= {17'h0, rpt_left_r, 3'h0,
                                 id_busy_r, warn_r, stat_desync_r,
                                 drive_r, enabled_led};
            default:          reg_rdata <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic ok_run;
   assign ok_run = nv_done_r && !id_busy_r;

   a_idle_drive_low: assert property (@(posedge clk_sys) disable iff (reset)
      (st_r == ST_IDLE) |-> !drive_r)
      else $error("drive active while idle");
   a_key_disables: assert property (@(posedge clk_sys) disable iff (reset)
      (ok_run && key_press && st_r != ST_IDLE) |=> st_r == ST_IDLE)
      else $error("key press did not disable");
   a_refuse_open_ilk: assert property (@(posedge clk_sys) disable iff (reset)
      (st_r == ST_IDLE && !pin_s_r.ilk_closed) |=> st_r == ST_IDLE)
      else $error("enabled with interlock open");
   a_ilk_closes: assert property (@(posedge clk_sys) disable iff (reset)
      (ok_run && ilk_drop) |=> (!coil_drive && warn_r
      && st_r == ST_IDLE))
      else $error("interlock did not close shutter");
   a_gate_follow: assert property (@(posedge clk_sys) disable iff (reset)
      (ok_run && st_r == ST_GATE && !key_press && !ilk_drop)
      |=> drive_r == $past(pin_s_r.trig))
      else $error("gate drive not following trigger");
   a_ttl_source: assert property (@(posedge clk_sys) disable iff (reset)
      1'b1 |=> ttl_out == ($past(pin_s_r.present)
      ? $past(pin_s_r.sensed_open) : $past(drive_r)))
      else $error("ttl output wrong source");
   a_phase_expire: assert property (@(posedge clk_sys) disable iff (reset)
      (ok_run && st_r == ST_OPEN && expire && !key_press && !ilk_drop
      && !cyc_end) |=> (st_r == ST_CLOSED && !drive_r
      && ph_cnt_r == $past(cfg_r.closed_ms)))
      else $error("open phase did not hand over");
   a_desync_flag: assert property (@(posedge clk_sys) disable iff (reset)
      desync_p |=> (desync_alarm && stat_desync_r))
      else $error("desync not flagged");
   a_no_sensor: assert property (@(posedge clk_sys) disable iff (reset)
      !pin_s_r.present |-> !desync_p)
      else $error("alarm without sensing shutter");
   a_mode_step: assert property (@(posedge clk_sys) disable iff (reset)
      (nv_done_r && reg_wr && reg_addr == `SHTS_OFS_STEP
      && reg_wdata[`SHTS_STEP_UP])
      |=> cfg_r.mode == mode_step($past(cfg_r.mode), 1'b1))
      else $error("mode step wrong");
   a_id_hold: assert property (@(posedge clk_sys) disable iff (reset)
      id_busy_r |=> st_r == ST_IDLE)
      else $error("operation during identification");

   c_manual: cover property (@(posedge clk_sys) disable iff (reset)
      st_r == ST_IDLE ##1 st_r == ST_MANUAL);
   c_rpt_done: cover property (@(posedge clk_sys) disable iff (reset)
      cfg_r.mode == MODE_REPEAT && st_r == ST_CLOSED ##1 st_r == ST_IDLE);
   c_desync: cover property (@(posedge clk_sys) disable iff (reset)
      desync_p);
   c_gate: cover property (@(posedge clk_sys) disable iff (reset)
      st_r == ST_GATE && drive_r);

endmodule // shts_seq

/* shts_shutter_model.sv */
// Purpose: Shutter blade with optical position sensor
// Assumes: Blade settles MOVE_CYC cycles after the coil changes
// Notes:   jam holds the blade open to provoke a disagreement
`timescale 1ns/1ps
module shts_shutter_model #(
   parameter int MOVE_CYC = 2
)
(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic coil_drive,
   input  wire logic jam,
   output logic      sensed_open
);
   logic [MOVE_CYC-1:0] blade_r;

   // Mechanical lag, MOVE_CYC of at least 2
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         blade_r <= '0;
      else
         blade_r <= {blade_r[MOVE_CYC-2:0], coil_drive};
   end
   assign sensed_open = jam | blade_r[MOVE_CYC-1];
endmodule // shts_shutter_model

/* shts_seq_test.sv */
// Purpose: Self-checking bench for shts_seq
// Assumes: TICK_CYC shortened to 4 cycles a ms
// Notes:   Modes are reached through the step register
`timescale 1ns/1ps
`include "shts_map.svh"
module shts_seq_test;
   import shts_pkg::*;
   localparam int T = 4;
   logic        clk_sys, reset, reg_wr, reg_rd, nv_valid, nv_save;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic        key, trig, ilk, pres, jam, sensed, coil_q;
   logic        coil_drive, ttl_out, enabled_led, interlock_warn;
   logic        desync_alarm, id_screen;
   shts_cfg_t   nv_cfg, nv_cfg_save;
   shts_pins_t  pins;
   int          error_cnt, n_compared, n, alarms, rises, cyc_cnt, run;
   int          last_len, saves, al0;

   assign pins = {key, trig, ilk, pres, sensed};
   shts_seq #(.TICK_CYC(T)) i_shts_seq (.clk_sys, .reset, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pins, .nv_valid, .nv_cfg,
      .nv_cfg_save, .nv_save, .coil_drive, .ttl_out, .enabled_led,
      .interlock_warn, .desync_alarm, .id_screen);
   shts_shutter_model i_shts_shutter_model (.clk_sys, .reset, .coil_drive,
      .jam, .sensed_open(sensed));

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Pulse counts, phase lengths and hang guard
   always @(posedge clk_sys)
   begin
      cyc_cnt  <= cyc_cnt + 1;
      alarms   <= alarms + int'(desync_alarm === 1'b1);
      saves    <= saves + int'(nv_save === 1'b1);
      rises    <= rises + int'(coil_drive === 1'b1 && coil_q === 1'b0);
      coil_q   <= coil_drive;
      run      <= (coil_drive !== coil_q) ? 1 : run + 1;
      if (coil_drive !== coil_q)
         last_len <= run;
      if (cyc_cnt == 40000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task chk_rng(input string nm, input int lo, input int hi, input int s);
      chk(nm, 32'(lo), (s >= lo && s <= hi) ? 32'(lo) : 32'(s));
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task press;
      @(posedge clk_sys) key <= 1'b1;
      cyc(4);
      @(posedge clk_sys) key <= 1'b0;
      cyc(6);
   endtask
   task set_mode(input shts_mode_t m);
      repeat (5)
      begin
         rd(`SHTS_OFS_CTRL);
         if (d[6:4] !== m)
            wr(`SHTS_OFS_STEP, 32'h1);
      end
   endtask
   task wait_coil(input logic v);
      n = 0;
      while (coil_drive !== v && n < 2000)
      begin
         cyc(1);
         n++;
      end
   endtask
   task end_of_test;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {reg_wr, reg_rd, key, trig, pres, jam, nv_valid, coil_q} = '0;
      {error_cnt, n_compared, alarms, rises, cyc_cnt, run, last_len} = '0;
      {saves, al0} = '0;
      {reg_addr, reg_wdata, nv_cfg} = '0;
      reset = 1'b1;
      ilk = 1'b1;
      cyc(2);
      chk("id_rst", 1, id_screen);
      @(posedge clk_sys) reset <= 1'b0;
      cyc(1);
      n = 0;
      while (id_screen === 1'b1 && n < 9000)
      begin
         cyc(1);
         n++;
      end
      chk_rng("id_len", 2000 * T - 4, 2000 * T + 2, n);
      rd(`SHTS_OFS_CTRL);
      chk("mode_rst", MODE_MANUAL, d[6:4]);
      rd(8'h3C);
      chk("unmapped", 0, d);
      wr(`SHTS_OFS_OPEN, 0);
      rd(`SHTS_OFS_OPEN);
      chk("open_min", `SHTS_DUR_MIN_MS, d);
      wr(`SHTS_OFS_CLOSED, 32'hFFFFF);
      rd(`SHTS_OFS_CLOSED);
      chk("closed_max", `SHTS_DUR_MAX_MS, d);
      wr(`SHTS_OFS_REPEAT, 32'h64);
      rd(`SHTS_OFS_REPEAT);
      chk("rpt_max", `SHTS_RPT_MAX, d);
      for (int i = 0; i < 5; i++)
      begin
         wr(`SHTS_OFS_STEP, 32'h1);
         rd(`SHTS_OFS_CTRL);
         chk("step", (i + 3) % 5, d[6:4]);
      end
      wr(`SHTS_OFS_STEP, 32'h2);
      rd(`SHTS_OFS_CTRL);
      chk("step_dn", MODE_CONT, d[6:4]);
      wr(`SHTS_OFS_STEP, 32'h1);
      @(posedge clk_sys) ilk <= 1'b0;
      press;
      chk("ilk_refuse", 0, enabled_led);
      chk("save_refused", 0, saves);
      @(posedge clk_sys) {ilk, pres, jam} <= 3'b111;
      n = alarms;
      press;
      chk("man_open", 1, coil_drive);
      chk("man_led", 1, enabled_led);
      chk("saved", MODE_MANUAL, nv_cfg_save.mode);
      chk("save_once", 1, saves);
      press;
      chk("man_close", 0, coil_drive);
      chk("ttl_sense", 1, ttl_out);
      chk("desync", n + 1, alarms);
      rd(`SHTS_OFS_STATUS);
      chk("desync_st", 1, d[2]);
      wr(`SHTS_OFS_STATUS, 32'h4);
      rd(`SHTS_OFS_STATUS);
      chk("desync_clr", 0, d[2]);
      @(posedge clk_sys) pres <= 1'b0;
      n = alarms;
      press;
      chk("ttl_drive", 1, ttl_out);
      press;
      chk("no_desync", n, alarms);
      @(posedge clk_sys) jam <= 1'b0;
      wr(`SHTS_OFS_OPEN, 5);
      wr(`SHTS_OFS_CLOSED, 4);
      set_mode(MODE_SINGLE);
      press;
      wait_coil(1'b0);
      cyc(1);
      chk_rng("open_len", 4 * T - 3, 5 * T, last_len);
      n = 0;
      while (enabled_led !== 1'b0 && n < 100)
      begin
         cyc(1);
         n++;
      end
      chk_rng("closed_len", 4 * T - 2, 4 * T, n);
      wr(`SHTS_OFS_CTRL, 2);
      press;
      chk("closed_first", 2, {enabled_led, coil_drive});
      wait_coil(1'b1);
      wait_coil(1'b0);
      cyc(4);
      chk_rng("open_len2", 5 * T - 1, 5 * T + 1, last_len);
      chk("single_end", 0, enabled_led);
      wr(`SHTS_OFS_CTRL, 0);
      wr(`SHTS_OFS_OPEN, 2);
      wr(`SHTS_OFS_CLOSED, 2);
      set_mode(MODE_CONT);
      @(posedge clk_sys) pres <= 1'b1;
      {n, al0} = {rises, alarms};
      press;
      cyc(80);
      chk_rng("cont_runs", n + 4, n + 6, rises);
      chk("cont_sync", al0, alarms);
      press;
      chk("key_stop", 0, {enabled_led, coil_drive});
      press;
      cyc(6);
      @(posedge clk_sys) ilk <= 1'b0;
      cyc(4);
      chk("ilk_trip", 0, coil_drive);
      rd(`SHTS_OFS_STATUS);
      chk("ilk_warn", 1, d[3]);
      n = 0;
      while (interlock_warn !== 1'b1 && n < 1100)
      begin
         cyc(1);
         n++;
      end
      chk("ilk_flash", 1, interlock_warn);
      @(posedge clk_sys) ilk <= 1'b1;
      cyc(20);
      chk("no_resume", 0, {enabled_led, coil_drive});
      wr(`SHTS_OFS_CTRL, 1);
      wr(`SHTS_OFS_REPEAT, 3);
      set_mode(MODE_REPEAT);
      @(posedge clk_sys) trig <= 1'b1;
      cyc(10);
      chk("pin_trig_idle", 0, enabled_led);
      n = rises;
      press;
      cyc(20);
      chk("armed", 2, {enabled_led, coil_drive});
      @(posedge clk_sys) trig <= 1'b0;
      cyc(200);
      chk("rpt_runs", n + 3, rises);
      chk("rpt_stop", 0, enabled_led);
      wr(`SHTS_OFS_CTRL, 0);
      set_mode(MODE_GATE);
      press;
      @(posedge clk_sys) trig <= 1'b1;
      cyc(4);
      chk("gate_hi", 1, coil_drive);
      @(posedge clk_sys) trig <= 1'b0;
      cyc(4);
      chk("gate_lo", 0, coil_drive);
      @(posedge clk_sys) {nv_valid, reset} <= 2'b11;
      nv_cfg <= nv_cfg_save;
      cyc(3);
      @(posedge clk_sys) reset <= 1'b0;
      cyc(2);
      rd(`SHTS_OFS_CTRL);
      chk("restored", MODE_GATE, d[6:4]);
      end_of_test();
   end
endmodule // shts_seq_test
